// file: rtl/lsc_params.svh
/*
 * Timing and protocol constants for the low-speed control block.
 * Assumes a single core clock; included by bare name.
 */
`ifndef LSC_PARAMS_SVH
`define LSC_PARAMS_SVH
`define LSC_DEV_ADDR      7'h50
`define LSC_CORE_CLK_NS   100
`define LSC_PTR_W         8
`define LSC_MEM_WORDS     256
`define LSC_BYTE_BITS     4'h8
`define LSC_BIT_ZERO      4'h0
`define LSC_ACK_BIT       4'h8
`define LSC_PTR_ONE       8'h01
`define LSC_SYNC_INIT     5'h1f
`endif

// file: rtl/lsc_pkg.sv
/*
 * Types shared by the low-speed control block.
 * Assumes lsc_params.svh is on the include path.
 */
`default_nettype none
package lsc_pkg;
	// Two-wire slave sequencer states
	typedef enum logic [2:0] {
		SL_IDLE,
		SL_ADDR,
		SL_ACK_ADDR,
		SL_WRITE,
		SL_ACK_WR,
		SL_READ,
		SL_ACK_RD
	} lsc_sl_state_t;

	// Status and alarm inputs from the module's analog side
	typedef struct packed {
		logic light_missing;
		logic tx_lock_lost;
		logic rx_lock_lost;
		logic attention_cause;
	} lsc_status_t;

	// Pin-facing outputs
	typedef struct packed {
		logic tx_laser_on;
		logic rx_light_missing;
		logic module_fault_flag;
		logic attention_oe;
		logic low_power;
	} lsc_pins_t;
endpackage
`default_nettype wire

// file: rtl/lsc_sync.sv
/*
 * Two-flip-flop synchroniser for a vector of levels.
 * Assumes inputs are asynchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module lsc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         core_clk,
	input  wire logic         nrst,
	input  wire logic         clk_en,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	// ===========================================
	// Elaboration checks
	if (W < 1)
		$error("W must be at least one");

	// Both stages in one struct
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stage2;
	} lsc_sync_state_t;

	lsc_sync_state_t s_r;
	lsc_sync_state_t s_nxt;

	// ===========================================
	// Capture chain; first stage feeds only the second
	always_comb
	begin
		s_nxt.meta   = async_in;
		s_nxt.stage2 = s_r.meta;
	end

	// Reset value chosen to match the idle level of each line
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			s_r <= {INIT, INIT};
		else if (clk_en)
			s_r <= s_nxt;
	end

	assign sync_out = s_r.stage2;
endmodule // lsc_sync
`default_nettype wire

// file: rtl/lsc_top.sv
/*
 * Low-speed control and two-wire management slave of a pluggable module.
 * Assumes host pins arrive asynchronously and the host pulls up open lines.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lsc_params.svh"

// Summary of operation
// - Transmitter off while the disable request is high, on while low.
// - Undriven disable and power/reset inputs read high, i.e. asserted.
// - Loss-of-light output high when optical input power is too low.
// - Two-wire traffic answered only while deselect input is low.
// - Slave answers at seven-bit address 1010000, eighth bit gives direction.
// - Attention output asserted on important condition; cause readable over bus.
// - Absent output tied to ground; host pulls it up.
// - Not-ready output high on operational fault, low otherwise.
// - Not-ready equals transmit lock-lost OR receive lock-lost.
// - Low power mode while power/reset input is high; optional feature.
// - Falling edge of power/reset input resets the bus sequencer and pointer and pulses logic_reset_pulse.
// - ID, diagnostics and control served over the two-wire bus.
module lsc_top #(
	parameter int  MEM_WORDS     = `LSC_MEM_WORDS,
	parameter bit  POWER_DOWN_EN = 1'b1
) (
	input  wire logic                core_clk,
	input  wire logic                nrst,
	input  wire logic                clk_en,
	input  wire logic                tx_off_request,
	input  wire logic                tx_off_driven,
	input  wire logic                pwr_rst_in,
	input  wire logic                pwr_rst_driven,
	input  wire logic                bus_deselect,
	input  wire logic                scl_in,
	input  wire logic                sda_in,
	output logic                     sda_out,
	output logic                     sda_oe,
	input  wire lsc_pkg::lsc_status_t status_in,
	input  wire logic [7:0]          diag_wr_data,
	input  wire logic [7:0]          diag_wr_addr,
	input  wire logic                diag_wr_en,
	output logic                     module_absent_flag,
	output lsc_pkg::lsc_pins_t       pins,
	output logic                     ctrl_wr_pulse,
	output logic [7:0]               ctrl_wr_addr,
	output logic [7:0]               ctrl_wr_data,
	output logic                     logic_reset_pulse
);
	localparam int PW = `LSC_PTR_W;

	// ===========================================
	// Elaboration checks
	if (MEM_WORDS < 2 || MEM_WORDS > (1 << PW))
		$error("MEM_WORDS out of range for pointer width");

	// Module state in one struct
	typedef struct packed {
		lsc_pkg::lsc_sl_state_t st;
		logic [3:0]             bitn;
		logic [7:0]             shreg;
		logic [PW-1:0]          ptr;
		logic                   ptr_loaded;
		logic                   rd_dir;
		logic                   sda_low;
		logic                   scl_d;
		logic                   sda_d;
		logic                   rst_d;
		logic                   wr_pulse;
		logic [7:0]             wr_addr;
		logic [7:0]             wr_data;
		logic                   rst_pulse;
		lsc_pkg::lsc_pins_t     pins;
	} lsc_state_t;

	lsc_state_t s_r;
	lsc_state_t s_nxt;
	logic [7:0] mem [MEM_WORDS];
	logic [7:0] rd_byte;

	// ===========================================
	// Input conditioning
	// pull-up modelled by forcing high when undriven
	logic tx_off_eff;
	logic pwr_rst_eff;
	assign tx_off_eff  = tx_off_request | ~tx_off_driven;
	assign pwr_rst_eff = pwr_rst_in | ~pwr_rst_driven;

	// all host-side levels through two flops
	logic [4:0] syn;
	lsc_sync #(
		.W    (5),
		.INIT (`LSC_SYNC_INIT)
	) u_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.clk_en   (clk_en),
		.async_in ({tx_off_eff, pwr_rst_eff, bus_deselect, scl_in, sda_in}),
		.sync_out (syn)
	);
	logic tx_off_s, pwr_s, desel_s, scl_s, sda_s;
	assign {tx_off_s, pwr_s, desel_s, scl_s, sda_s} = syn;

	// Bus events seen on the synchronised lines
	logic scl_rise, scl_fall, start_c, stop_c, rst_fall;
	assign scl_rise = scl_s & ~s_r.scl_d;
	assign scl_fall = ~scl_s & s_r.scl_d;
	assign start_c  = scl_s & s_r.scl_d & s_r.sda_d & ~sda_s;
	assign stop_c   = scl_s & s_r.scl_d & ~s_r.sda_d & sda_s;
	// falling edge found on the synchronised power/reset level
	assign rst_fall = s_r.rst_d & ~pwr_s;

	// Pointer step, used after every data byte
	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == PW'(MEM_WORDS - 1)) ? '0 : p + PW'(`LSC_PTR_ONE);
	endfunction

	// ===========================================
	// Management memory: host writes and diagnostic updates
	// ID and diagnostics live here; writes are exported as controls
	assign rd_byte = (s_r.ptr == '0) ? {7'h00, status_in.attention_cause}
	                                 : mem[s_r.ptr];
	always_ff @(posedge core_clk)
	begin
		if (clk_en)
		begin
			if (diag_wr_en && (32'(diag_wr_addr) < MEM_WORDS))
				mem[diag_wr_addr[PW-1:0]] <= diag_wr_data;
			else if (s_r.wr_pulse)
				mem[s_r.wr_addr[PW-1:0]] <= s_r.wr_data;
		end
	end

	// ===========================================
	// Next state
	always_comb
	begin
		s_nxt           = s_r;
		s_nxt.scl_d     = scl_s;
		s_nxt.sda_d     = sda_s;
		s_nxt.rst_d     = pwr_s;
		s_nxt.wr_pulse  = 1'b0;
		s_nxt.rst_pulse = 1'b0;

		s_nxt.pins.tx_laser_on = ~tx_off_s;
		s_nxt.pins.rx_light_missing = status_in.light_missing;
		// TX lock lost OR RX lock lost
		s_nxt.pins.module_fault_flag = status_in.tx_lock_lost | status_in.rx_lock_lost;
		// open-collector attention pulled low while cause stands
		s_nxt.pins.attention_oe = status_in.attention_cause;
		// limited power while power/reset high, if supported
		s_nxt.pins.low_power = POWER_DOWN_EN & pwr_s;

		// deselect mid-frame releases the bus and drops the frame
		if (desel_s)
		begin
			s_nxt.st      = lsc_pkg::SL_IDLE;
			s_nxt.sda_low = 1'b0;
		end
		else if (start_c)
		begin
			s_nxt.st      = lsc_pkg::SL_ADDR;
			s_nxt.bitn    = `LSC_BIT_ZERO;
			s_nxt.sda_low = 1'b0;
		end
		else if (stop_c)
		begin
			s_nxt.st      = lsc_pkg::SL_IDLE;
			s_nxt.sda_low = 1'b0;
		end
		else
		begin
			unique case (s_r.st)
				lsc_pkg::SL_IDLE:
					s_nxt.sda_low = 1'b0;
				lsc_pkg::SL_ADDR, lsc_pkg::SL_WRITE:
				begin
					if (scl_rise)
					begin
						s_nxt.shreg = {s_r.shreg[6:0], sda_s};
						s_nxt.bitn  = s_r.bitn + 4'h1;
					end
					if (scl_fall && s_r.bitn == `LSC_BYTE_BITS)
					begin
						if (s_r.st == lsc_pkg::SL_ADDR)
						begin
							if (s_r.shreg[7:1] == `LSC_DEV_ADDR)
							begin
								s_nxt.rd_dir  = s_r.shreg[0];
								s_nxt.sda_low = 1'b1;
								s_nxt.st      = lsc_pkg::SL_ACK_ADDR;
							end
							else
								s_nxt.st = lsc_pkg::SL_IDLE;
						end
						else
						begin
							if (!s_r.ptr_loaded)
							begin
								s_nxt.ptr        = s_r.shreg[PW-1:0];
								s_nxt.ptr_loaded = 1'b1;
							end
							else
							begin
								s_nxt.wr_pulse = 1'b1;
								s_nxt.wr_addr  = 8'(s_r.ptr);
								s_nxt.wr_data  = s_r.shreg;
								s_nxt.ptr      = ptr_inc(s_r.ptr);
							end
							s_nxt.sda_low = 1'b1;
							s_nxt.st      = lsc_pkg::SL_ACK_WR;
						end
					end
				end
				lsc_pkg::SL_ACK_ADDR, lsc_pkg::SL_ACK_WR:
				begin
					// After the acknowledge clock ends, release SDA or drive the first read bit
					if (scl_fall)
					begin
						s_nxt.bitn = `LSC_BIT_ZERO;
						if (s_r.st == lsc_pkg::SL_ACK_ADDR && s_r.rd_dir)
						begin
							s_nxt.shreg   = rd_byte;
							s_nxt.sda_low = ~rd_byte[7];
							s_nxt.st      = lsc_pkg::SL_READ;
						end
						else
						begin
							if (s_r.st == lsc_pkg::SL_ACK_ADDR)
								s_nxt.ptr_loaded = 1'b0;
							s_nxt.sda_low = 1'b0;
							s_nxt.st      = lsc_pkg::SL_WRITE;
						end
					end
				end
				lsc_pkg::SL_READ:
				begin
					if (scl_rise)
						s_nxt.bitn = s_r.bitn + 4'h1;
					if (scl_fall)
					begin
						if (s_r.bitn == `LSC_BYTE_BITS)
						begin
							s_nxt.sda_low = 1'b0;
							s_nxt.ptr     = ptr_inc(s_r.ptr);
							s_nxt.st      = lsc_pkg::SL_ACK_RD;
						end
						else
						begin
							s_nxt.shreg   = {s_r.shreg[6:0], 1'b0};
							s_nxt.sda_low = ~s_r.shreg[6];
						end
					end
				end
				lsc_pkg::SL_ACK_RD:
				begin
					// Master ACK continues, NACK ends the read
					if (scl_rise)
						s_nxt.rd_dir = ~sda_s;
					if (scl_fall)
					begin
						s_nxt.bitn = `LSC_BIT_ZERO;
						if (s_r.rd_dir)
						begin
							s_nxt.shreg   = rd_byte;
							s_nxt.sda_low = ~rd_byte[7];
							s_nxt.st      = lsc_pkg::SL_READ;
						end
						else
							s_nxt.st = lsc_pkg::SL_IDLE;
					end
				end
				default:
					s_nxt.st = lsc_pkg::SL_IDLE;
			endcase
		end

		// falling edge of power/reset idles the sequencer and clears the pointer
		if (rst_fall)
		begin
			s_nxt.st         = lsc_pkg::SL_IDLE;
			s_nxt.sda_low    = 1'b0;
			s_nxt.ptr        = '0;
			s_nxt.ptr_loaded = 1'b0;
			s_nxt.wr_pulse   = 1'b0;
			s_nxt.rst_pulse  = 1'b1;
		end
	end

	// ===========================================
	// State register; reset holds laser off and flags low
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_r       <= '0;
			s_r.st    <= lsc_pkg::SL_IDLE;
			s_r.scl_d <= 1'b1;
			s_r.sda_d <= 1'b1;
			s_r.rst_d <= 1'b1;
		end
		else if (clk_en)
			s_r <= s_nxt;
	end

	// ===========================================
	// Outputs
	// presence line tied to ground inside the module
	assign module_absent_flag = 1'b0;
	assign pins               = s_r.pins;
	assign sda_out            = 1'b0;
	assign sda_oe             = s_r.sda_low;
	assign ctrl_wr_pulse      = s_r.wr_pulse;
	assign ctrl_wr_addr       = s_r.wr_addr;
	assign ctrl_wr_data       = s_r.wr_data;
	assign logic_reset_pulse  = s_r.rst_pulse;
endmodule // lsc_top
`default_nettype wire

// file: tb/lsc_top_props.sv
/* Port checker for lsc_top, bound into the design.
   Assumes default parameters; warm-up restarts whenever clk_en drops. */
`timescale 1ns/1ps
`default_nettype none
// ========
// Checker
module lsc_top_props (
	input wire logic                 core_clk,
	input wire logic                 nrst,
	input wire logic                 clk_en,
	input wire logic                 tx_off_request,
	input wire logic                 tx_off_driven,
	input wire logic                 pwr_rst_in,
	input wire logic                 pwr_rst_driven,
	input wire logic                 bus_deselect,
	input wire logic                 sda_out,
	input wire logic                 sda_oe,
	input wire lsc_pkg::lsc_status_t status_in,
	input wire logic                 module_absent_flag,
	input wire lsc_pkg::lsc_pins_t   pins,
	input wire logic                 ctrl_wr_pulse,
	input wire logic                 logic_reset_pulse
);
	logic [1:0] up_r;
	logic       tx_req;
	logic       pw_req;
	// Floating pins count as asserted
	assign tx_req = tx_off_request | ~tx_off_driven;
	assign pw_req = pwr_rst_in | ~pwr_rst_driven;
	// Warm-up count keeps $past clear of reset values
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
			up_r <= 2'h0;
		else if (!clk_en)
			up_r <= 2'h0;
		else if (up_r != 2'h3)
			up_r <= up_r + 2'h1;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	a_laser_off_req: assert property (up_r == 2'h3 |->
		pins.tx_laser_on == !$past(tx_req, 3))
		else $error("laser state does not follow disable request");
	a_los_level: assert property (up_r == 2'h3 |->
		pins.rx_light_missing == $past(status_in.light_missing))
		else $error("loss of light wrong");
	a_fault_or: assert property (up_r == 2'h3 |-> pins.module_fault_flag ==
		($past(status_in.tx_lock_lost) | $past(status_in.rx_lock_lost)))
		else $error("fault flag wrong");
	a_absent_low: assert property (module_absent_flag == 1'b0 && sda_out == 1'b0)
		else $error("absent or data out not low");
	a_power_level: assert property (up_r == 2'h3 |-> pins.low_power == $past(pw_req, 3))
		else $error("low power wrong");
	a_reset_fall: assert property (up_r == 2'h3 && $past(pw_req, 4) && !$past(pw_req, 3)
		|-> logic_reset_pulse)
		else $error("no reset pulse");
	a_desel_quiet: assert property (up_r == 2'h3 && $past(bus_deselect, 3) |-> !sda_oe)
		else $error("data driven while deselected");
	a_wr_single: assert property (ctrl_wr_pulse |=> !ctrl_wr_pulse)
		else $error("write pulse too long");
	c_reset: cover property (logic_reset_pulse);
	c_write: cover property (ctrl_wr_pulse);
	c_ack: cover property (sda_oe);
endmodule // lsc_top_props
bind lsc_top lsc_top_props lsc_top_props_inst (.*);
`default_nettype wire

// file: tb/lsc_host.sv
/* Two-wire host master model, 800 ns bus clock.
   Assumes the bench resolves SDA with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
// ========
// Host
module lsc_host (
	input  wire logic core_clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	// Bus released; the clock stands still between frames
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic cy(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// Start, also usable as a repeated start
	task automatic start;
		cy(2);
		sda_low <= 1'b0;
		cy(2);
		scl <= 1'b1;
		cy(4);
		sda_low <= 1'b1;
		cy(4);
		scl <= 1'b0;
	endtask
	task automatic stop;
		cy(2);
		sda_low <= 1'b1;
		cy(2);
		scl <= 1'b1;
		cy(4);
		sda_low <= 1'b0;
		cy(4);
	endtask
	// Byte MSB first plus ninth bit; a 1 releases SDA
	task automatic xf(input logic [7:0] d, input logic last, output logic [7:0] q,
		output logic ack);
		logic [8:0] w;
		w = {d, last};
		for (int i = 8; i >= 0; i--)
		begin
			cy(2);
			sda_low <= ~w[i];
			cy(2);
			scl <= 1'b1;
			cy(2);
			@(negedge core_clk);
			w[i] = sda;
			cy(2);
			scl <= 1'b0;
		end
		q = w[8:1];
		ack = w[0];
	endtask
endmodule // lsc_host
`default_nettype wire

// file: tb/tb_top.sv
/* Self-checking bench for lsc_top.
   Assumes lsc_host as bus master and default parameters. */
`timescale 1ns/1ps
`default_nettype none
// ========
// Bench
module tb_top;
	logic core_clk, nrst, tx_off_request, tx_off_driven, pwr_rst_in, pwr_rst_driven;
	logic bus_deselect, sda_oe, sda_in, scl, sda_low, ack;
	logic ctrl_wr_pulse, logic_reset_pulse, module_absent_flag, clk_en, diag_wr_en;
	logic [7:0] diag_wr_addr, diag_wr_data;
	logic [7:0] ctrl_wr_addr, ctrl_wr_data, q, wr_a, wr_d;
	lsc_pkg::lsc_status_t status_in;
	lsc_pkg::lsc_pins_t   pins;
	int n_mismatch = 0, tests_run = 0, cyc = 0, n_rst = 0, n_wr = 0;
	// Host pull-up: a released line reads high
	assign sda_in = ~(sda_low | sda_oe);
	lsc_top lsc_top_inst (.*, .scl_in(scl), .sda_out());
	lsc_host lsc_host_inst (.core_clk(core_clk), .sda(sda_in), .scl(scl), .sda_low(sda_low));
	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// Pulse monitor and hang limit
	always @(posedge core_clk)
	begin
		cyc++;
		if (logic_reset_pulse === 1'b1)
			n_rst++;
		if (ctrl_wr_pulse === 1'b1)
		begin
			n_wr++;
			wr_a = ctrl_wr_addr;
			wr_d = ctrl_wr_data;
		end
		if (cyc == 10000)
		begin
			n_mismatch++;
			test_done();
		end
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// Every status value and every disable setting, floating pin included
	task automatic t_pins;
		for (int i = 0; i < 16; i++)
		begin
			@(posedge core_clk);
			{tx_off_driven, tx_off_request} <= i[1:0];
			status_in <= lsc_pkg::lsc_status_t'(i[3:0]);
			w(4);
			@(negedge core_clk);
			chk(8'(pins.tx_laser_on), 8'(i[1] & ~i[0]));
			chk(8'(pins.rx_light_missing), 8'(i[3]));
			chk(8'(pins.module_fault_flag), 8'(i[2] | i[1]));
			chk(8'(pins.attention_oe), 8'(i[0]));
			chk(8'(module_absent_flag), 8'h00);
		end
	endtask
	task automatic adr(input logic [7:0] a);
		lsc_host_inst.start();
		lsc_host_inst.xf(a, 1'b1, q, ack);
	endtask
	task automatic wb(input logic [7:0] d);
		lsc_host_inst.xf(d, 1'b1, q, ack);
		chk(8'(ack), 8'h00);
	endtask
	// Clock enable low freezes the pins; they catch up once it returns
	task automatic t_freeze;
		@(posedge core_clk);
		clk_en <= 1'b0;
		tx_off_request <= 1'b0;
		w(6);
		@(negedge core_clk);
		chk(8'(pins.tx_laser_on), 8'h00);
		@(posedge core_clk);
		clk_en <= 1'b1;
		w(4);
		@(negedge core_clk);
		chk(8'(pins.tx_laser_on), 8'h01);
	endtask
	// Pointer byte then two data bytes; the pointer steps after each
	task automatic t_write;
		adr(8'hA0);
		chk(8'(ack), 8'h00);
		wb(8'h05);
		wb(8'h3C);
		chk(8'(n_wr), 8'h01);
		chk(wr_a, 8'h05);
		chk(wr_d, 8'h3C);
		wb(8'hC3);
		lsc_host_inst.stop();
		chk(8'(n_wr), 8'h02);
		chk(wr_a, 8'h06);
		chk(wr_d, 8'hC3);
	endtask
	// Pointer set, repeated start, one or two bytes read; NACK ends it
	task automatic t_read(input logic [7:0] p, input logic [7:0] e, input logic [7:0] e2,
		input logic two);
		adr(8'hA0);
		wb(p);
		adr(8'hA1);
		chk(8'(ack), 8'h00);
		lsc_host_inst.xf(8'hFF, ~two, q, ack);
		chk(q, e);
		if (two)
		begin
			lsc_host_inst.xf(8'hFF, 1'b1, q, ack);
			chk(q, e2);
		end
		lsc_host_inst.stop();
	endtask
	// Single-clock diagnostic update with the bus idle, then read back over the bus
	task automatic t_diag;
		@(posedge core_clk);
		diag_wr_addr <= 8'h07;
		diag_wr_data <= 8'h5A;
		diag_wr_en <= 1'b1;
		@(posedge core_clk);
		diag_wr_en <= 1'b0;
		t_read(8'h07, 8'h5A, 8'h00, 1'b0);
	endtask
	task automatic t_refuse;
		adr(8'hA2);
		chk(8'(ack), 8'h01);
		lsc_host_inst.stop();
		@(posedge core_clk);
		bus_deselect <= 1'b1;
		w(4);
		adr(8'hA0);
		chk(8'(ack), 8'h01);
		lsc_host_inst.stop();
		@(posedge core_clk);
		bus_deselect <= 1'b0;
	endtask
	// Floating pin, then two falling edges
	task automatic t_power;
		n_rst = 0;
		@(posedge core_clk);
		pwr_rst_driven <= 1'b0;
		w(4);
		@(negedge core_clk);
		chk(8'(pins.low_power), 8'h01);
		for (int k = 1; k <= 2; k++)
		begin
			@(posedge core_clk);
			pwr_rst_driven <= 1'b1;
			pwr_rst_in <= 1'b0;
			w(6);
			@(negedge core_clk);
			chk(8'(pins.low_power), 8'h00);
			chk(8'(n_rst), 8'(k));
			@(posedge core_clk);
			pwr_rst_in <= 1'b1;
			w(6);
		end
	endtask
	initial
	begin
		nrst = 1'b0;
		tx_off_request = 1'b0;
		tx_off_driven = 1'b1;
		pwr_rst_in = 1'b0;
		pwr_rst_driven = 1'b1;
		bus_deselect = 1'b0;
		status_in = 4'h0;
		clk_en = 1'b1;
		diag_wr_en = 1'b0;
		diag_wr_addr = 8'h00;
		diag_wr_data = 8'h00;
		w(3);
		nrst <= 1'b1;
		w(3);
		t_pins();
		t_freeze();
		t_write();
		t_read(8'h05, 8'h3C, 8'hC3, 1'b1);
		t_diag();
		t_read(8'h00, 8'h01, 8'h00, 1'b0);
		t_refuse();
		t_power();
		test_done();
	end
endmodule // tb_top
`default_nettype wire
